// *** rtl/seh_map.svh ***
// Constants for the SPI EEPROM serial front end
`ifndef SEH_MAP_SVH
`define SEH_MAP_SVH
`define SEH_WORDS       262144
`define SEH_WORD_BITS   8
`define SEH_ADDR_BITS   18
`define SEH_BITCNT_W    3
`define SEH_BIT_MSB     3'h7
`endif

// *** rtl/seh_pkg.sv ***
// Types for the SPI EEPROM serial front end
package seh_pkg;
   typedef enum logic [1:0] {
      SEH_IDLE,
      SEH_ACTIVE,
      SEH_HELD
   } seh_state_t;
endpackage

// *** rtl/seh_sync.sv ***
// Two-flop synchroniser with edge detection on the synchronised side
`timescale 1ns/1ns
`default_nettype none
module seh_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q,
   output var  logic [W-1:0] q_prev
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_nxt;
   logic [W-1:0] s3_nxt;

   always_comb begin
      s1_nxt = d;
      s2_nxt = s1_r;
      s3_nxt = q;
   end

   // Reset to idle levels: select and suspend high
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r   <= {W{1'b1}};
         q      <= {W{1'b1}};
         q_prev <= {W{1'b1}};
      end else begin
         s1_r   <= s1_nxt;
         q      <= s2_nxt;
         q_prev <= s3_nxt;
      end
   end
endmodule
`default_nettype wire

// *** rtl/seh_front.sv ***
// Serial front end: bit sampling, bit shifting and suspend
// Notes on behaviour
// RL1 - Serial input bits are taken on each rising clock edge.
// RL2 - Serial output changes after each falling clock edge.
// RL3 - Suspend low while selected pauses the transfer, keeping all state; resumed at a byte boundary, output stays released until the next falling edge.
// RL4 - Master lowers suspend only while the serial clock is low.
// RL5 - Master raises suspend only with clock low; edges meanwhile are ignored.
// RL6 - While suspended, input is ignored and output is released.
// RL7 - Array holds 262144 bytes; the address steps by one for each byte after the first in a transfer.
// RL8 - Only active while select is low; otherwise input ignored, output released.
// RL9 - Modes 0 and 3 accepted; clock idle level equal before and after; in mode 0 the first output byte comes one bit late.
// RL10 - Bytes shift most significant bit first.
`timescale 1ns/1ns
`default_nettype none
`include "seh_map.svh"
module seh_front (
   input  wire logic                      SYS_CLK,
   input  wire logic                      RST,
   input  wire logic                      SCK,
   input  wire logic                      CS_N,
   input  wire logic                      SI,
   input  wire logic                      HOLD_N,
   input  wire logic [`SEH_WORD_BITS-1:0] TX_BYTE,
   output logic                           SO_O,
   output logic                           SO_OE,
   output logic [`SEH_WORD_BITS-1:0]      RX_BYTE,
   output logic                           RX_VALID,
   output logic                           TX_LOAD,
   output logic [`SEH_ADDR_BITS-1:0]      WORD_ADDR,
   output logic                           SELECTED,
   output logic                           SUSPENDED
);
   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   logic [3:0] pin_q;
   logic [3:0] pin_p;

   seh_sync #(.W(4)) u_sync (
      .clk    (SYS_CLK),
      .rst    (RST),
      .d      ({SCK, CS_N, SI, HOLD_N}),
      .q      (pin_q),
      .q_prev (pin_p)
   );

   logic sck_s;
   logic cs_n_s;
   logic si_s;
   logic hold_n_s;
   logic sck_rise;
   logic sck_fall;
   always_comb begin
      sck_s    = pin_q[3];
      cs_n_s   = pin_q[2];
      si_s     = pin_q[1];
      hold_n_s = pin_q[0];
      sck_rise = sck_s & ~pin_p[3];                                     // RL9
      sck_fall = ~sck_s & pin_p[3];                                     // RL9
   end

   // ----------------------------------------
   // Sequence state
   // ----------------------------------------
   seh_pkg::seh_state_t            st_r, st_nxt;
   logic [`SEH_BITCNT_W-1:0]       bcnt_r, bcnt_nxt;
   logic [`SEH_WORD_BITS-1:0]      rsh_r, rsh_nxt;
   logic [`SEH_WORD_BITS-1:0]      tsh_r, tsh_nxt;
   logic [`SEH_ADDR_BITS-1:0]      addr_r, addr_nxt;
   logic                           so_r, so_nxt;
   logic                           oe_r, oe_nxt;
   logic                           rxv_r, rxv_nxt;
   logic                           ld_r, ld_nxt;
   logic [`SEH_WORD_BITS-1:0]      rxb_r, rxb_nxt;
   logic                           first_r, first_nxt;
   logic                           sel_r, sel_nxt;
   logic                           susp_r, susp_nxt;

   always_comb begin
      st_nxt    = st_r;
      bcnt_nxt  = bcnt_r;
      rsh_nxt   = rsh_r;
      tsh_nxt   = tsh_r;
      addr_nxt  = addr_r;
      so_nxt    = so_r;
      oe_nxt    = oe_r;
      rxv_nxt   = 1'b0;
      ld_nxt    = 1'b0;
      rxb_nxt   = rxb_r;
      first_nxt = first_r;
      if (cs_n_s) begin
         // Deselect ends the sequence; state restarts on next select
         st_nxt   = seh_pkg::SEH_IDLE;                                  // RL8
         oe_nxt   = 1'b0;                                               // RL8
         bcnt_nxt = '0;
         first_nxt = 1'b1;
      end else begin
         case (st_r)
            seh_pkg::SEH_IDLE: begin
               st_nxt  = seh_pkg::SEH_ACTIVE;
               tsh_nxt = TX_BYTE;
            end
            seh_pkg::SEH_ACTIVE: begin
               // Suspend only honoured with clock low; master keeps to that
               if (!hold_n_s && !sck_s) begin
                  st_nxt = seh_pkg::SEH_HELD;                           // RL3 RL4
                  oe_nxt = 1'b0;                                        // RL6
               end else begin
                  if (sck_rise) begin
                     rsh_nxt  = {rsh_r[`SEH_WORD_BITS-2:0], si_s};      // RL1 RL10
                     bcnt_nxt = bcnt_r + 3'h1;
                     if (bcnt_r == `SEH_BIT_MSB) begin
                        rxb_nxt   = {rsh_r[`SEH_WORD_BITS-2:0], si_s};
                        rxv_nxt   = 1'b1;
                        ld_nxt    = 1'b1;
                        tsh_nxt   = TX_BYTE;
                        first_nxt = 1'b0;
                        if (!first_r) begin
                           addr_nxt = addr_r + 18'h00001;               // RL7
                        end
                     end
                  end
                  if (sck_fall) begin
                     so_nxt  = tsh_r[`SEH_WORD_BITS-1];                 // RL2 RL10
                     tsh_nxt = {tsh_r[`SEH_WORD_BITS-2:0], 1'b0};
                     oe_nxt  = 1'b1;
                  end
               end
            end
            seh_pkg::SEH_HELD: begin
               oe_nxt = 1'b0;                                           // RL6
               if (hold_n_s && !sck_s) begin
                  st_nxt = seh_pkg::SEH_ACTIVE;                         // RL5
                  oe_nxt = bcnt_r != 3'h0;
               end
            end
            default: st_nxt = seh_pkg::SEH_IDLE;
         endcase
      end
      // Flags registered so every port comes from a flop
      sel_nxt  = st_nxt != seh_pkg::SEH_IDLE;                            // RL8
      susp_nxt = st_nxt == seh_pkg::SEH_HELD;                            // RL3
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         st_r    <= seh_pkg::SEH_IDLE;
         bcnt_r  <= '0;
         rsh_r   <= '0;
         tsh_r   <= '0;
         addr_r  <= '0;
         so_r    <= 1'b0;
         oe_r    <= 1'b0;
         rxv_r   <= 1'b0;
         ld_r    <= 1'b0;
         rxb_r   <= '0;
         first_r <= 1'b1;
         sel_r   <= 1'b0;
         susp_r  <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         bcnt_r  <= bcnt_nxt;
         rsh_r   <= rsh_nxt;
         tsh_r   <= tsh_nxt;
         addr_r  <= addr_nxt;
         so_r    <= so_nxt;
         oe_r    <= oe_nxt;
         rxv_r   <= rxv_nxt;
         ld_r    <= ld_nxt;
         rxb_r   <= rxb_nxt;
         first_r <= first_nxt;
         sel_r   <= sel_nxt;
         susp_r  <= susp_nxt;
      end
   end

   always_comb begin
      SO_O      = so_r;
      SO_OE     = oe_r;
      RX_BYTE   = rxb_r;
      RX_VALID  = rxv_r;
      TX_LOAD   = ld_r;
      WORD_ADDR = addr_r;
      SELECTED  = sel_r;
      SUSPENDED = susp_r;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   chk_deselect_release: assert property (cs_n_s |=> !oe_r)   // RL8
      else $error("output driven while deselected");
   chk_hold_release: assert property (st_r == seh_pkg::SEH_HELD |-> !oe_r) // RL6
      else $error("output driven while suspended");
   chk_hold_freeze: assert property (st_r == seh_pkg::SEH_HELD && $past(st_r) == seh_pkg::SEH_HELD // RL3
      |-> $stable(bcnt_r) && $stable(rsh_r) && $stable(addr_r))
      else $error("state changed during suspend");
   chk_rise_shift: assert property (st_r == seh_pkg::SEH_ACTIVE && !cs_n_s && sck_rise && hold_n_s // RL1
      |=> rsh_r[0] == $past(si_s) && bcnt_r == $past(bcnt_r) + 3'h1)
      else $error("bit not taken on rising edge");
   chk_fall_drive: assert property (st_r == seh_pkg::SEH_ACTIVE && !cs_n_s && sck_fall && hold_n_s // RL2
      |=> oe_r && so_r == $past(tsh_r[7]))
      else $error("output not shifted on falling edge");
   chk_no_change_rise: assert property (st_r == seh_pkg::SEH_ACTIVE && sck_rise |=> $stable(so_r))  // RL2
      else $error("output moved on rising edge");
   chk_byte_done: assert property (rxv_r |-> bcnt_r == 3'h0 && ld_r)   // RL10
      else $error("byte flag out of step");
   chk_addr_step: assert property (rxv_r && !$past(first_r) |-> addr_r == $past(addr_r) + 18'h00001)  // RL7
      else $error("address did not step");
   chk_hold_enter: assert property (st_r == seh_pkg::SEH_ACTIVE && !cs_n_s && !hold_n_s && !sck_s // RL3
      |=> st_r == seh_pkg::SEH_HELD && susp_r && !oe_r)
      else $error("suspend not entered");
   chk_resume_low: assert property ($past(st_r) == seh_pkg::SEH_HELD && st_r == seh_pkg::SEH_ACTIVE // RL5
      |-> !$past(sck_s))
      else $error("resumed with clock high");
   chk_rx_pulse: assert property (rxv_r |=> !rxv_r)   // RL7
      else $error("byte flag longer than one cycle");

   cov_byte: cover property (rxv_r);
   cov_hold: cover property (st_r == seh_pkg::SEH_HELD ##[1:200] st_r == seh_pkg::SEH_ACTIVE);
   cov_drive: cover property (oe_r && so_r);
   cov_resume_mid: cover property (st_r == seh_pkg::SEH_HELD ##1 st_r == seh_pkg::SEH_ACTIVE && oe_r);
endmodule
`default_nettype wire

// *** bench/seh_master.sv ***
// Behavioural SPI bus master facing the serial front end
`timescale 1ns/1ns
`default_nettype none
module seh_master (
   output var logic sck,
   output var logic cs_n,
   output var logic si,
   output var logic hold_n,
   input  wire logic so_o,
   input  wire logic so_oe,
   input  wire logic susp,
   output var logic hold_ok
);
   // Released line shows the inverse so a stale bit cannot pass
   wire so_w = so_oe ? so_o : ~so_o;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
      hold_ok = 1'b0;
   end
   // -------------------------
   // Transfers
   // -------------------------
   task automatic xfer(input logic m3, input logic [15:0] tx, input logic [1:0] nb, input int h,
                       output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      sck = m3;
      #400 cs_n = 1'b0;
      #400;
      for (i = 0; i < nb * 8; i++) begin
         sck = 1'b0;
         si = tx[nb*8-1-i];
         #200;
         if (i == h) begin
            hold_n = 1'b0;
            #400;
            repeat (2) begin
               si = ~si;
               sck = 1'b1;
               #200 sck = 1'b0;
               #200;
            end
            hold_ok = susp & ~so_oe;
            si = tx[nb*8-1-i];
            hold_n = 1'b1;
            #400;
         end
         rx = {rx[14:0], so_w};
         sck = 1'b1;
         #200;
      end
      sck = m3;
      #200 cs_n = 1'b1;
      #400;
   endtask
   task automatic idle();
      repeat (8) begin
         si = ~si;
         #200 sck = ~sck;
      end
   endtask
endmodule
`default_nettype wire

// *** bench/tb_seh_front.sv ***
// Self-checking bench for the serial front end
`timescale 1ns/1ns
`default_nettype none
`include "seh_map.svh"
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_seh_front;
   typedef struct packed {logic m3; logic [1:0] nb; logic [15:0] si_v; logic [7:0] tx0; logic [7:0] tx1;} seh_row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  txb = 8'h00;
   logic [15:0] rx;
   wire         sck, cs_n, si, hold_n, so_o, so_oe, rx_valid, sel, susp, hold_ok, tx_load;
   wire [7:0]   rx_byte;
   wire [17:0]  addr;
   int          n_fail = 0;
   int          checked = 0;
   int          n_rx = 0;
   int          n_ld = 0;
   int          exp_addr = 0;
   int          k;
   seh_row_t    rows [4] = '{'{1'b0, 2'h1, 16'h00A5, 8'h3C, 8'h00}, '{1'b1, 2'h1, 16'h0081, 8'h7E, 8'h00},
                             '{1'b1, 2'h2, 16'hFF00, 8'hC3, 8'h5A}, '{1'b1, 2'h2, 16'h0180, 8'h01, 8'hFE}};
   always #25 clk = ~clk;
   always @(negedge clk) if (rx_valid === 1'b1) n_rx++;
   always @(negedge clk) if (tx_load === 1'b1) n_ld++;
   seh_front i_seh_front (.SYS_CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .SI(si), .HOLD_N(hold_n),
      .TX_BYTE(txb), .SO_O(so_o), .SO_OE(so_oe), .RX_BYTE(rx_byte), .RX_VALID(rx_valid), .TX_LOAD(tx_load),
      .WORD_ADDR(addr), .SELECTED(sel), .SUSPENDED(susp));
   seh_master i_seh_master (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe),
      .susp(susp), .hold_ok(hold_ok));
   task automatic end_sim();
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // -------------------------
   // One framed transfer
   // -------------------------
   task automatic run(input seh_row_t r, input int h);
      int n0;
      n0 = n_rx;
      @(posedge clk) #2 txb = r.tx0;
      fork
         i_seh_master.xfer(r.m3, r.si_v, r.nb, h, rx);
         begin #1000; @(posedge clk) #2 txb = r.tx1;
            `CHK("selected", 1'b1, sel)
         end
      join
      exp_addr += r.nb - 1;
      `CHK("rx_byte", r.si_v[7:0], rx_byte)
      `CHK("rx_count", n0 + r.nb, n_rx)
      `CHK("ld_count", n0 + r.nb, n_ld)
      `CHK("deselected", 1'b0, sel)
      `CHK("addr", exp_addr[17:0], addr)
      if (r.m3 && r.nb == 2'h2) `CHK("so_bits", {r.tx0, r.tx1}, rx)
      if (r.m3 && r.nb == 2'h1) `CHK("so_bits", r.tx0, rx[7:0])
      if (!r.m3) `CHK("so_bits", r.tx0[7:1], rx[6:0])
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #2 rst = 1'b0;
      `CHK("so_oe", 1'b0, so_oe)
      `CHK("selected", 1'b0, sel)
      `CHK("addr", 18'h00000, addr)
      repeat (4) @(posedge clk);
      for (k = 0; k < 4; k++) run(rows[k], 99);
      run(seh_row_t'{1'b1, 2'h1, 16'h0096, 8'h69, 8'h00}, 3);
      `CHK("hold_state", 1'b1, hold_ok)
      k = n_rx;
      i_seh_master.idle();
      `CHK("idle_rx", k, n_rx)
      `CHK("idle_oe", 1'b0, so_oe)
      `CHK("idle_byte", 8'h96, rx_byte)
      @(posedge clk) #2 rst = 1'b1;
      repeat (2) @(posedge clk);
      #2 `CHK("addr_rst", 18'h00000, addr)
      @(posedge clk) #2 rst = 1'b0;
      `CHK("sel_rst", 1'b0, sel)
      @(posedge clk) #2 `CHK("oe_rst", 1'b0, so_oe)
      exp_addr = 0;
      repeat (2) @(posedge clk);
      run(rows[0], 99);
      end_sim();
   end
   initial begin
      #2000000;
      n_fail++;
      end_sim();
   end
endmodule
`default_nettype wire
